// file: core/prpd_port_core.sv
// Port A-C registers, global pull-up disable and port D override logic.
// Function
// R1: USART A receiver on forces port D bit 0 to input.
// R2: Forced-input bit 0 pull-up follows its latch bit and global pull-up disable.
// R3: Port D bit 0 drives pin-change source 24.
// R4: Bits 7..4 take compare output value when enabled; pull-up and direction untouched.
// R5: Input-enable override asserts with value 1 when mask bit and group 3 set.
// R6: Bits 3/1 transmitter forces output, no pull-up; bit 2 receiver forces input.
// R7: Two-wire enable inserts spike filters on bit 0/1 inputs and slew control.
// R8: Global pull-up disable kills every pull-up, even direction 0 latch 1.
// R9: System control at 0x35, resets zero, bits 3 and 2 read-only.
// R10: Port A latch at 0x02, read/write, resets zero.
// R11: Port A direction at 0x01, read/write, resets zero, pins start inputs.
// R12: Port A pin input at 0x00 reflects pin levels.
// R13: Port B pin, direction, latch at 0x03, 0x04, 0x05.
// R14: Port C pin, direction, latch at 0x06, 0x07, 0x08.
// R15: USART A transmitter on forces port D bit 1 to output.
// R16: Compare waveform reaches pin only when its direction bit is output.
// R17: Pin input reads pass a two-flop synchroniser.
// R18: Bit 0 overrides keyed to USART A receiver enable.
`timescale 1ns/1ps

module prpd_port_core
	import prpd_pkg::*;
#(
	parameter int SPIKE_LEN = SPIKE_SAMPLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// Ports A..C pins
	input wire logic [DATA_W-1:0] port_a_pin_i,
	input wire logic [DATA_W-1:0] port_b_pin_i,
	input wire logic [DATA_W-1:0] port_c_pin_i,
	output logic [DATA_W-1:0] port_a_out_o,
	output logic [DATA_W-1:0] port_b_out_o,
	output logic [DATA_W-1:0] port_c_out_o,
	output logic [DATA_W-1:0] port_a_oe_n_o,
	output logic [DATA_W-1:0] port_b_oe_n_o,
	output logic [DATA_W-1:0] port_c_oe_n_o,
	output logic [DATA_W-1:0] port_a_pullup_o,
	output logic [DATA_W-1:0] port_b_pullup_o,
	output logic [DATA_W-1:0] port_c_pullup_o,
	output logic global_pullup_off_o,
	output logic [DATA_W-1:0] system_control_o,
	// Port D register state and pin
	input wire logic [DATA_W-1:0] portd_latch_i,
	input wire logic [DATA_W-1:0] portd_direction_i,
	input wire logic [DATA_W-1:0] portd_pin_i,
	output logic [DATA_W-1:0] portd_out_o,
	output logic [DATA_W-1:0] portd_oe_n_o,
	output logic [DATA_W-1:0] portd_pullup_o,
	// Peripheral overrides for port D
	input wire logic uart_a_receiver_on_i,
	input wire logic uart_a_transmitter_on_i,
	input wire logic uart_b_receiver_on_i,
	input wire logic uart_b_transmitter_on_i,
	input wire logic uart_a_tx_data_i,
	input wire logic uart_b_tx_data_i,
	input wire logic [3:0] compare_enable_i,
	input wire logic [3:0] compare_value_i,
	input wire logic [DATA_W-1:0] pin_change_mask_i,
	input wire logic pin_change_group3_on_i,
	input wire logic twi_enable_i,
	// Port D input paths
	output logic [DATA_W-1:0] pin_change_source_o,
	output logic [DATA_W-1:0] input_enable_override_enable_o,
	output logic [DATA_W-1:0] input_enable_override_value_o,
	output logic uart_a_receive_pin_o,
	output logic uart_b_receive_pin_o,
	output logic external_irq_zero_o,
	output logic external_irq_one_o,
	output logic timer1_capture_input_o,
	output logic [1:0] twi_pin_filtered_o,
	output logic [1:0] slew_rate_control_o
);

	// --------------------------------------------------
	// Register file state
	// --------------------------------------------------
	logic [DATA_W-1:0] latch [NUM_PORTS];
	logic [DATA_W-1:0] direction [NUM_PORTS];
	logic [DATA_W-1:0] sync1 [NUM_PORTS];
	logic [DATA_W-1:0] sync2 [NUM_PORTS];
	logic [DATA_W-1:0] pins_raw [NUM_PORTS];
	logic [DATA_W-1:0] system_control;
	logic [DATA_W-1:0] portd_sync1;
	logic [DATA_W-1:0] portd_sync2;
	logic global_off;
	assign pins_raw[0] = port_a_pin_i;
	assign pins_raw[1] = port_b_pin_i;
	assign pins_raw[2] = port_c_pin_i;
	assign global_off = system_control[GLOBAL_PULLUP_OFF_BIT];

	// Pull-up on only for an input with latch high and no global disable
	function automatic logic [DATA_W-1:0] pullup_of(input logic [DATA_W-1:0] dir, input logic [DATA_W-1:0] lat,
			input logic off);
		pullup_of = ~dir & lat & {DATA_W{~off}}; // R8
	endfunction

	// --------------------------------------------------
	// Latch and direction registers for ports A..C
	// --------------------------------------------------
	// A write of ones to the pin input register toggles the latch bits
	always_ff @(posedge mclk_i) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (rst_i) begin
				latch[p] <= OUTPUT_LATCH_RST; // R10 R13 R14
				direction[p] <= DIRECTION_RST; // R11 R13 R14
			end else if (wr_i) begin
				if (addr_i == OUTPUT_LATCH_OFS[p]) begin
					latch[p] <= wdata_i; // R10 R13 R14
				end else if (addr_i == PIN_INPUT_OFS[p]) begin
					latch[p] <= latch[p] ^ wdata_i;
				end
				if (addr_i == DIRECTION_OFS[p]) begin
					direction[p] <= wdata_i; // R11 R13 R14
				end
			end
		end
	end

	// System control register, bits 3:2 always read zero
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			system_control <= SYSTEM_CONTROL_RST; // R9
		end else if (wr_i && addr_i == SYSTEM_CONTROL_OFS) begin
			system_control <= wdata_i & SYSTEM_CONTROL_WR_MASK; // R9
		end
	end

	// --------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------
	// Pins are asynchronous; only the second stage is ever read
	always_ff @(posedge mclk_i) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (rst_i) begin
				sync1[p] <= '0;
				sync2[p] <= '0;
			end else begin
				sync1[p] <= pins_raw[p]; // R17
				sync2[p] <= sync1[p]; // R17 R12
			end
		end
	end

	// Port D pins take the same two-flop path
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			portd_sync1 <= '0;
			portd_sync2 <= '0;
		end else begin
			portd_sync1 <= portd_pin_i; // R17
			portd_sync2 <= portd_sync1;
		end
	end

	// --------------------------------------------------
	// Read port
	// --------------------------------------------------
	// Data stand only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge mclk_i) begin
		if (rst_i || !rd_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (addr_i == PIN_INPUT_OFS[p]) begin
					rdata_o <= sync2[p]; // R12 R13 R14
				end
				if (addr_i == DIRECTION_OFS[p]) begin
					rdata_o <= direction[p];
				end
				if (addr_i == OUTPUT_LATCH_OFS[p]) begin
					rdata_o <= latch[p];
				end
			end
			if (addr_i == SYSTEM_CONTROL_OFS) begin
				rdata_o <= system_control; // R9
			end
		end
	end

	// --------------------------------------------------
	// Ports A..C pin drive
	// --------------------------------------------------
	// Registered so the pad sees glitch-free levels
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			port_a_out_o <= '0;
			port_b_out_o <= '0;
			port_c_out_o <= '0;
			port_a_oe_n_o <= '1;
			port_b_oe_n_o <= '1;
			port_c_oe_n_o <= '1;
			port_a_pullup_o <= '0;
			port_b_pullup_o <= '0;
			port_c_pullup_o <= '0;
			global_pullup_off_o <= 1'b0;
			system_control_o <= '0;
		end else begin
			port_a_out_o <= latch[0];
			port_b_out_o <= latch[1];
			port_c_out_o <= latch[2];
			port_a_oe_n_o <= ~direction[0]; // R11
			port_b_oe_n_o <= ~direction[1];
			port_c_oe_n_o <= ~direction[2];
			port_a_pullup_o <= pullup_of(direction[0], latch[0], global_off); // R8
			port_b_pullup_o <= pullup_of(direction[1], latch[1], global_off); // R8
			port_c_pullup_o <= pullup_of(direction[2], latch[2], global_off); // R8
			global_pullup_off_o <= global_off;
			system_control_o <= system_control;
		end
	end

	// --------------------------------------------------
	// Port D overrides
	// --------------------------------------------------
	logic [DATA_W-1:0] next_pd_out;
	logic [DATA_W-1:0] next_pd_dir;
	logic [DATA_W-1:0] next_pd_pull;

	// Start from the generic pin, then let each peripheral take over
	always_comb begin
		next_pd_out = portd_latch_i;
		next_pd_dir = portd_direction_i;
		next_pd_pull = pullup_of(portd_direction_i, portd_latch_i, global_off); // R8
		if (uart_a_receiver_on_i) begin
			next_pd_dir[PD_UART_A_RX] = 1'b0; // R1 R18
			next_pd_pull[PD_UART_A_RX] = portd_latch_i[PD_UART_A_RX] & ~global_off; // R2 R18
		end
		if (uart_a_transmitter_on_i) begin
			next_pd_dir[PD_UART_A_TX] = 1'b1; // R15 R6
			next_pd_pull[PD_UART_A_TX] = 1'b0; // R6
			next_pd_out[PD_UART_A_TX] = uart_a_tx_data_i; // R6
		end
		if (uart_b_receiver_on_i) begin
			next_pd_dir[PD_UART_B_RX] = 1'b0; // R6
			next_pd_pull[PD_UART_B_RX] = portd_latch_i[PD_UART_B_RX] & ~global_off; // R6
		end
		if (uart_b_transmitter_on_i) begin
			next_pd_dir[PD_UART_B_TX] = 1'b1; // R6
			next_pd_pull[PD_UART_B_TX] = 1'b0; // R6
			next_pd_out[PD_UART_B_TX] = uart_b_tx_data_i; // R6
		end
		// Compare outputs replace only the value; direction still gates them
		for (int i = 0; i < 4; i++) begin
			if (compare_enable_i[i]) begin
				next_pd_out[PD_COMPARE_LSB + i] = compare_value_i[i]; // R4 R16
			end
		end
	end

	// Port D pad drive
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			portd_out_o <= '0;
			portd_oe_n_o <= '1;
			portd_pullup_o <= '0;
		end else begin
			portd_out_o <= next_pd_out;
			portd_oe_n_o <= ~next_pd_dir; // R16
			portd_pullup_o <= next_pd_pull;
		end
	end

	// Input-enable override and input fan-out
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			input_enable_override_enable_o <= '0;
			input_enable_override_value_o <= '0;
			pin_change_source_o <= '0;
			uart_a_receive_pin_o <= 1'b0;
			uart_b_receive_pin_o <= 1'b0;
			external_irq_zero_o <= 1'b0;
			external_irq_one_o <= 1'b0;
			timer1_capture_input_o <= 1'b0;
			slew_rate_control_o <= '0;
		end else begin
			input_enable_override_enable_o <= pin_change_mask_i & {DATA_W{pin_change_group3_on_i}}; // R5
			input_enable_override_value_o <= pin_change_mask_i & {DATA_W{pin_change_group3_on_i}}; // R5
			pin_change_source_o <= portd_sync2; // R3 R5
			uart_a_receive_pin_o <= portd_sync2[PD_UART_A_RX];
			uart_b_receive_pin_o <= portd_sync2[PD_UART_B_RX];
			external_irq_zero_o <= portd_sync2[PD_UART_B_RX];
			external_irq_one_o <= portd_sync2[PD_UART_B_TX];
			timer1_capture_input_o <= portd_sync2[PD_TIMER1_CAPTURE]; // R5
			slew_rate_control_o <= {2{twi_enable_i}}; // R7
		end
	end

	// --------------------------------------------------
	// Two-wire spike filter on bits 0 and 1
	// --------------------------------------------------
	// A level must hold SPIKE_LEN samples to pass; costs SPIKE_LEN+1 cycles of latency after the synchroniser
	logic [SPIKE_LEN-1:0] spike_hist [2];

	always_ff @(posedge mclk_i) begin
		for (int b = 0; b < 2; b++) begin
			if (rst_i) begin
				spike_hist[b] <= '0;
				twi_pin_filtered_o[b] <= 1'b0;
			end else begin
				spike_hist[b] <= {spike_hist[b][SPIKE_LEN-2:0], portd_sync2[b]};
				if (!twi_enable_i) begin
					twi_pin_filtered_o[b] <= portd_sync2[b];
				end else if (&spike_hist[b]) begin
					twi_pin_filtered_o[b] <= 1'b1; // R7
				end else if (~|spike_hist[b]) begin
					twi_pin_filtered_o[b] <= 1'b0; // R7
				end
			end
		end
	end

	// --------------------------------------------------
	// Assertions
	// --------------------------------------------------
	logic [1:0] warm;

	// Cycles since reset release, so pipelines hold real pin history
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			warm <= '0;
		end else if (warm != 2'h3) begin
			warm <= warm + 2'h1;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_write_latch_a;
		wr_i && addr_i == OUTPUT_LATCH_OFS[0];
	endsequence
	sequence s_read_latch_a;
		rd_i && addr_i == OUTPUT_LATCH_OFS[0];
	endsequence
	sequence s_write_dir_a;
		wr_i && addr_i == DIRECTION_OFS[0];
	endsequence
	sequence s_write_sysctl;
		wr_i && addr_i == SYSTEM_CONTROL_OFS;
	endsequence
	sequence s_read_sysctl;
		rd_i && addr_i == SYSTEM_CONTROL_OFS;
	endsequence

	property p_rx_a_input;
		uart_a_receiver_on_i |=> portd_oe_n_o[PD_UART_A_RX];
	endproperty
	a_rx_a_input: assert property (p_rx_a_input) else $error("bit 0 not input under receiver"); // R1

	property p_rx_a_pullup;
		uart_a_receiver_on_i
			|=> portd_pullup_o[PD_UART_A_RX] == ($past(portd_latch_i[PD_UART_A_RX]) & ~$past(global_off));
	endproperty
	a_rx_a_pullup: assert property (p_rx_a_pullup) else $error("bit 0 pull-up wrong"); // R2

	property p_pin_change_src24;
		warm == 2'h3 |-> pin_change_source_o[0] == $past(portd_pin_i[0], 3);
	endproperty
	a_pin_change_src24: assert property (p_pin_change_src24) else $error("pin change 24 mismatch"); // R3

	property p_compare_b7;
		compare_enable_i[3] && portd_direction_i[7] |=> !portd_oe_n_o[7] && portd_out_o[7] == $past(compare_value_i[3]);
	endproperty
	a_compare_b7: assert property (p_compare_b7) else $error("compare value not on bit 7"); // R4

	property p_ie_override;
		pin_change_group3_on_i && pin_change_mask_i[5]
			|=> input_enable_override_enable_o[5] && input_enable_override_value_o[5];
	endproperty
	a_ie_override: assert property (p_ie_override) else $error("input enable override missing"); // R5

	property p_tx_b;
		uart_b_transmitter_on_i |=> !portd_oe_n_o[3] && !portd_pullup_o[3] && portd_out_o[3] == $past(uart_b_tx_data_i);
	endproperty
	a_tx_b: assert property (p_tx_b) else $error("bit 3 transmit override wrong"); // R6

	property p_tx_a;
		uart_a_transmitter_on_i |=> !portd_oe_n_o[PD_UART_A_TX];
	endproperty
	a_tx_a: assert property (p_tx_a) else $error("bit 1 not output under transmitter"); // R15

	property p_pullup_off_all;
		global_off |=> port_a_pullup_o == '0 && port_b_pullup_o == '0 && port_c_pullup_o == '0 && portd_pullup_o == '0;
	endproperty
	a_pullup_off_all: assert property (p_pullup_off_all) else $error("pull-up on under global disable"); // R8

	property p_sysctl_ro;
		s_write_sysctl ##1 s_read_sysctl
			|=> rdata_o == ($past(wdata_i, 2) & SYSTEM_CONTROL_WR_MASK) && global_pullup_off_o == $past(wdata_i[4], 2);
	endproperty
	a_sysctl_ro: assert property (p_sysctl_ro) else $error("system control readback wrong"); // R9

	property p_latch_a_rw;
		s_write_latch_a ##1 s_read_latch_a |=> rdata_o == $past(wdata_i, 2);
	endproperty
	a_latch_a_rw: assert property (p_latch_a_rw) else $error("port A latch readback wrong"); // R10

	property p_dir_a_drive;
		s_write_dir_a |=> ##1 port_a_oe_n_o == ~$past(wdata_i, 2);
	endproperty
	a_dir_a_drive: assert property (p_dir_a_drive) else $error("port A direction not driven"); // R11

	property p_pin_a_sync;
		warm == 2'h3 && rd_i && addr_i == PIN_INPUT_OFS[0] |=> rdata_o == $past(port_a_pin_i, 3);
	endproperty
	a_pin_a_sync: assert property (p_pin_a_sync) else $error("port A pin read not synchronised"); // R17

endmodule

// file: include/prpd_pkg.sv
// Constants shared by the port register and port D override logic.
package prpd_pkg;

	// --------------------------------------------------
	// Bus and port geometry
	// --------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_PORTS = 3;

	// --------------------------------------------------
	// Register offsets (I/O space), index 0..2 = port A..C
	// --------------------------------------------------
	localparam logic [ADDR_W-1:0] PIN_INPUT_OFS [NUM_PORTS] = '{8'h00, 8'h03, 8'h06};
	localparam logic [ADDR_W-1:0] DIRECTION_OFS [NUM_PORTS] = '{8'h01, 8'h04, 8'h07};
	localparam logic [ADDR_W-1:0] OUTPUT_LATCH_OFS [NUM_PORTS] = '{8'h02, 8'h05, 8'h08};
	localparam logic [ADDR_W-1:0] SYSTEM_CONTROL_OFS = 8'h35;

	// --------------------------------------------------
	// Reset values and field layout
	// --------------------------------------------------
	localparam logic [DATA_W-1:0] DIRECTION_RST = 8'h00;
	localparam logic [DATA_W-1:0] OUTPUT_LATCH_RST = 8'h00;
	localparam logic [DATA_W-1:0] SYSTEM_CONTROL_RST = 8'h00;
	localparam logic [DATA_W-1:0] SYSTEM_CONTROL_WR_MASK = 8'hF3;
	localparam int GLOBAL_PULLUP_OFF_BIT = 4;

	// --------------------------------------------------
	// Port D bit positions
	// --------------------------------------------------
	localparam int PD_UART_A_RX = 0;
	localparam int PD_UART_A_TX = 1;
	localparam int PD_UART_B_RX = 2;
	localparam int PD_UART_B_TX = 3;
	localparam int PD_TIMER1_CAPTURE = 6;
	localparam int PD_COMPARE_LSB = 4;

	// --------------------------------------------------
	// Timing
	// --------------------------------------------------
	localparam int SPIKE_SAMPLES = 3;

endpackage

// file: dv/prpd_pin_model.sv
// Board-side model of the eight pins of one port.
`timescale 1ns/1ps

module prpd_pin_model (
	// Clock
	input wire logic mclk_i,
	// Device drive
	input wire logic [7:0] out_i,
	input wire logic [7:0] oe_n_i,
	input wire logic [7:0] pullup_i,
	// Board drive
	input wire logic [7:0] ext_val_i,
	input wire logic [7:0] ext_en_i,
	// Resolved levels
	output logic [7:0] pin_o
);
	// --------------------------------------------------
	// Pin resolution
	// --------------------------------------------------
	initial pin_o = 8'h00;
	// A floating pin toggles, so a stale value can never pass for a real one
	always @(posedge mclk_i) begin
		for (int i = 0; i < 8; i++) begin
			if (oe_n_i[i] == 1'h0) begin
				pin_o[i] <= out_i[i];
			end else if (ext_en_i[i] == 1'h1) begin
				pin_o[i] <= ext_val_i[i];
			end else if (pullup_i[i] == 1'h1) begin
				pin_o[i] <= 1'h1;
			end else begin
				pin_o[i] <= ~pin_o[i];
			end
		end
	end
endmodule

// file: dv/tb_top.sv
// Self-checking testbench for the port registers and port D overrides.
`timescale 1ns/1ps

module tb_top;
	import prpd_pkg::*;
	// --------------------------------------------------
	// Signals
	// --------------------------------------------------
	logic mclk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	logic wr_i = 1'h0, rd_i = 1'h0;
	// Index 3 is port D
	logic [7:0] out_v [4], oe_v [4], pu_v [4], pin_v [4], ext_v [4], ext_en [4];
	logic [7:0] d_latch = 8'h00, d_dir = 8'h00, pc_mask = 8'h00;
	logic rxa = 1'h0, txa = 1'h0, rxb = 1'h0, txb = 1'h0, tda = 1'h0, tdb = 1'h0, grp3 = 1'h0, twi = 1'h0;
	logic [3:0] cmp_en = 4'h0, cmp_val = 4'h0;
	logic gpo, rx_a, rx_b, irq0, irq1, icp;
	logic [7:0] sysctl, pcs, ieoe, ieov;
	logic [1:0] twi_f, slew;
	int err_total = 0, compares = 0, cycles = 0;

	// Clock at 125 MHz
	always #4 mclk_i = ~mclk_i;

	// --------------------------------------------------
	// Design and board pins
	// --------------------------------------------------
	prpd_port_core #(.SPIKE_LEN(3)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.port_a_pin_i(pin_v[0]), .port_b_pin_i(pin_v[1]), .port_c_pin_i(pin_v[2]),
		.port_a_out_o(out_v[0]), .port_b_out_o(out_v[1]), .port_c_out_o(out_v[2]),
		.port_a_oe_n_o(oe_v[0]), .port_b_oe_n_o(oe_v[1]), .port_c_oe_n_o(oe_v[2]),
		.port_a_pullup_o(pu_v[0]), .port_b_pullup_o(pu_v[1]), .port_c_pullup_o(pu_v[2]),
		.global_pullup_off_o(gpo), .system_control_o(sysctl),
		.portd_latch_i(d_latch), .portd_direction_i(d_dir), .portd_pin_i(pin_v[3]),
		.portd_out_o(out_v[3]), .portd_oe_n_o(oe_v[3]), .portd_pullup_o(pu_v[3]),
		.uart_a_receiver_on_i(rxa), .uart_a_transmitter_on_i(txa), .uart_b_receiver_on_i(rxb),
		.uart_b_transmitter_on_i(txb), .uart_a_tx_data_i(tda), .uart_b_tx_data_i(tdb),
		.compare_enable_i(cmp_en), .compare_value_i(cmp_val), .pin_change_mask_i(pc_mask),
		.pin_change_group3_on_i(grp3), .twi_enable_i(twi), .pin_change_source_o(pcs),
		.input_enable_override_enable_o(ieoe), .input_enable_override_value_o(ieov),
		.uart_a_receive_pin_o(rx_a), .uart_b_receive_pin_o(rx_b), .external_irq_zero_o(irq0),
		.external_irq_one_o(irq1), .timer1_capture_input_o(icp), .twi_pin_filtered_o(twi_f),
		.slew_rate_control_o(slew));

	for (genvar p = 0; p < 4; p++) begin : g_pin
		prpd_pin_model u_pin (.mclk_i(mclk_i), .out_i(out_v[p]), .oe_n_i(oe_v[p]), .pullup_i(pu_v[p]),
			.ext_val_i(ext_v[p]), .ext_en_i(ext_en[p]), .pin_o(pin_v[p]));
	end

	// --------------------------------------------------
	// Shared tasks
	// --------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge mclk_i);
		wr_i <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge mclk_i);
		rd_i <= 1'h0;
		#1;
		d = rdata_o;
	endtask

	// Write then read with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= wd;
		wr_i <= 1'h1;
		@(posedge mclk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h1;
		@(posedge mclk_i);
		rd_i <= 1'h0;
		#1;
		d = rdata_o;
	endtask

	task automatic complete_run;
		$display("Mismatches %0d, comparisons %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// --------------------------------------------------
	// Scenarios
	// --------------------------------------------------
	task automatic t_reset;
		logic [7:0] d;
		for (int p = 0; p < 3; p++) begin
			rd(DIRECTION_OFS[p], d);
			check("dir rst", d, 8'h00);
			rd(OUTPUT_LATCH_OFS[p], d);
			check("latch rst", d, 8'h00);
			check("oe_n rst", oe_v[p], 8'hFF);
		end
		rd(SYSTEM_CONTROL_OFS, d);
		check("sysctl rst", d, 8'h00);
	endtask

	// Writes one idle cycle apart, then read back and see the pin drive
	task automatic t_regs;
		logic [7:0] d, dv, lv;
		for (int p = 0; p < 3; p++) begin
			wr(DIRECTION_OFS[p], 8'hC3 + 8'(p));
			wr(OUTPUT_LATCH_OFS[p], 8'h5A + 8'(p));
		end
		for (int p = 0; p < 3; p++) begin
			dv = 8'hC3 + 8'(p);
			lv = 8'h5A + 8'(p);
			rd(DIRECTION_OFS[p], d);
			check("dir", d, dv);
			rd(OUTPUT_LATCH_OFS[p], d);
			check("latch", d, lv);
			check("drive", out_v[p], lv);
			check("oe_n", oe_v[p], ~dv);
			check("pullup", pu_v[p], ~dv & lv);
		end
		rd(8'h40, d);
		check("unmapped", d, 8'h00);
	endtask

	task automatic t_sysctl;
		logic [7:0] d;
		wr_rd(SYSTEM_CONTROL_OFS, 8'hFF, d);
		check("sysctl ro bits", d, 8'hF3);
		check("sysctl copy set", sysctl, 8'hF3);
		wr(DIRECTION_OFS[0], 8'h00);
		wr_rd(OUTPUT_LATCH_OFS[0], 8'hFF, d);
		check("latch b2b", d, 8'hFF);
		cyc(3);
		check("global off", {7'h00, gpo}, 8'h01);
		check("pullup off", pu_v[0], 8'h00);
		wr(SYSTEM_CONTROL_OFS, 8'h00);
		cyc(3);
		check("pullup on", pu_v[0], 8'hFF);
		check("sysctl copy", sysctl, 8'h00);
	endtask

	task automatic t_pins;
		logic [7:0] d;
		logic [7:0] v [3] = '{8'h96, 8'h69, 8'hC3};
		for (int p = 0; p < 3; p++) wr(DIRECTION_OFS[p], 8'h00);
		@(posedge mclk_i);
		for (int p = 0; p < 3; p++) begin
			ext_en[p] <= 8'hFF;
			ext_v[p] <= v[p];
		end
		cyc(6);
		for (int p = 0; p < 3; p++) begin
			rd(PIN_INPUT_OFS[p], d);
			check("pin input", d, v[p]);
		end
		@(posedge mclk_i);
		ext_v[0] <= ~v[0];
		rd(PIN_INPUT_OFS[0], d);
		check("sync lag", d, v[0]);
		cyc(4);
		rd(PIN_INPUT_OFS[0], d);
		check("synced", d, ~v[0]);
	endtask

	// All port D overrides at once, then all released
	task automatic t_portd;
		@(posedge mclk_i);
		d_dir <= 8'hB5;
		d_latch <= 8'hCF;
		{rxa, txa, tda, rxb, txb, tdb} <= 6'h3E;
		cmp_en <= 4'hF;
		cmp_val <= 4'hA;
		cyc(3);
		check("d oe_n", oe_v[3], 8'h45);
		check("d pullup", pu_v[3], 8'h45);
		check("d drive", out_v[3] & 8'hBA, 8'hA2);
		wr(SYSTEM_CONTROL_OFS, 8'h10);
		cyc(3);
		check("d pullup off", pu_v[3], 8'h00);
		wr(SYSTEM_CONTROL_OFS, 8'h00);
		@(posedge mclk_i);
		{rxa, txa, rxb, txb} <= 4'h0;
		cmp_en <= 4'h0;
		cyc(3);
		check("d plain oe_n", oe_v[3], 8'h4A);
		check("d plain drive", out_v[3], 8'hCF);
	endtask

	task automatic t_pinchg;
		logic [7:0] v;
		@(posedge mclk_i);
		d_dir <= 8'h00;
		pc_mask <= 8'hA1;
		grp3 <= 1'h1;
		ext_en[3] <= 8'hFF;
		cyc(3);
		check("ie ovr en", ieoe, 8'hA1);
		check("ie ovr val", ieov, 8'hA1);
		for (int k = 0; k < 2; k++) begin
			v = (k == 0) ? 8'h4D : 8'hB2;
			@(posedge mclk_i);
			ext_v[3] <= v;
			cyc(6);
			check("pc sources", pcs, v);
			check("taps", {3'h0, icp, irq1, irq0, rx_b, rx_a}, {3'h0, v[6], v[3], v[2], v[2], v[0]});
			check("twi idle", {6'h00, twi_f}, {6'h00, v[1:0]});
		end
		@(posedge mclk_i);
		grp3 <= 1'h0;
		cyc(3);
		check("ie ovr off", ieoe, 8'h00);
	endtask

	task automatic t_twi;
		int bad;
		bad = 0;
		@(posedge mclk_i);
		twi <= 1'h1;
		ext_v[3] <= 8'h00;
		cyc(8);
		check("slew", {6'h00, slew}, 8'h03);
		@(posedge mclk_i);
		ext_v[3] <= 8'h01;
		@(posedge mclk_i);
		ext_v[3] <= 8'h00;
		repeat (8) begin
			@(posedge mclk_i);
			#1;
			if (twi_f[0] !== 1'h0) bad = 1;
		end
		check("spike", 8'(bad), 8'h00);
		@(posedge mclk_i);
		ext_v[3] <= 8'h01;
		cyc(10);
		check("filtered", {6'h00, twi_f}, 8'h01);
		@(posedge mclk_i);
		twi <= 1'h0;
		cyc(3);
		check("slew off", {6'h00, slew}, 8'h00);
	endtask

	// --------------------------------------------------
	// Sequence and hang guard
	// --------------------------------------------------
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			complete_run();
		end
	end

	initial begin
		for (int p = 0; p < 4; p++) begin
			ext_v[p] = 8'h00;
			ext_en[p] = 8'h00;
		end
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'h0;
		t_reset();
		t_regs();
		t_sysctl();
		t_pins();
		t_portd();
		t_pinchg();
		t_twi();
		complete_run();
	end
endmodule
